/* verilog/ega_params.svh */
// constants for the compatibility register set
`ifndef EGA_PARAMS_SVH
`define EGA_PARAMS_SVH
`define EGA_PORT_ATTR0      10'h3c0
`define EGA_PORT_ATTR1      10'h3c1
`define EGA_PORT_MISC       10'h3c2
`define EGA_PORT_SEQ_IDX    10'h3c4
`define EGA_PORT_SEQ_DAT    10'h3c5
`define EGA_PORT_GFX_IDX    10'h3ce
`define EGA_PORT_GFX_DAT    10'h3cf
`define EGA_PORT_MONO_BASE  10'h3b0
`define EGA_PORT_COLOR_BASE 10'h3d0
`define EGA_OFS_CRT_IDX     4'h4
`define EGA_OFS_CRT_DAT     4'h5
`define EGA_OFS_STATUS1     4'ha
`define EGA_SEQ_CLOCKING    3'h1
`define EGA_SEQ_CHARMAP     3'h3
`define EGA_SEQ_MEMMODE     3'h4
`define EGA_CRT_START_HI    5'h0c
`define EGA_CRT_START_LO    5'h0d
`define EGA_CRT_CURS_HI     5'h0e
`define EGA_CRT_CURS_LO     5'h0f
`define EGA_CRT_PEN_HI      5'h10
`define EGA_CRT_PEN_LO      5'h11
`define EGA_MISC_COLOR_BIT  0
`define EGA_MISC_DRVOFF_BIT 4
`define EGA_MISC_CLK_LSB    2
`define EGA_CFG_CLK_BIT     3
`define EGA_ATTR_MAP_BIT    3
`define EGA_STAT0_SW_BIT    4
`define EGA_STAT1_PEN_SW    2
`define EGA_STAT1_PEN_TRIG  1
`define EGA_STAT0_ONES      8'h0f
`define EGA_STAT1_ONES      8'h40
`define EGA_MD_MONITOR_BIT  11
`define EGA_MD_SW_LSB       12
`define EGA_RESET_BYTE      8'h00
`define EGA_ERR_BYTE        8'hff
`endif

/* verilog/ega_pkg.sv */
// types for the compatibility register set
package ega_pkg;
  typedef enum logic [1:0] {
    EGA_CLK_BASE,
    EGA_CLK_SECONDARY,
    EGA_CLK_FEATURE,
    EGA_CLK_NONE
  } ega_dot_clk_t;
  typedef enum logic {
    EGA_STRAP_WAIT,
    EGA_STRAP_DONE
  } ega_strap_st_t;
endpackage : ega_pkg

/* verilog/ega_dot_clock_select.sv */
// dot clock source choice from misc output and configuration bit
`timescale 1ns/1ps
`default_nettype none
`include "ega_params.svh"
module ega_dot_clock_select
  import ega_pkg::*;
(
  input  wire logic [1:0]   clockSel,
  input  wire logic         cfgClkBit,
  output ega_dot_clk_t      dotClk
);
  always_comb begin
    unique case (clockSel)
      2'h0: dotClk = EGA_CLK_BASE;
      2'h1: dotClk = cfgClkBit ? EGA_CLK_NONE : EGA_CLK_SECONDARY;
      2'h2: dotClk = cfgClkBit ? EGA_CLK_NONE : EGA_CLK_FEATURE;
      2'h3: dotClk = cfgClkBit ? EGA_CLK_NONE : EGA_CLK_FEATURE;
    endcase
  end
endmodule : ega_dot_clock_select
`default_nettype wire

/* verilog/ega_compat_register_set.sv */
// register set of the controller in its EGA compatibility mode
`timescale 1ns/1ps
`default_nettype none
`include "ega_params.svh"
module ega_compat_register_set
  import ega_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          srst,
  // host I/O bus, same clock
  input  wire logic [9:0]    ioAddr,
  input  wire logic          ioWr,
  input  wire logic          ioRd,
  input  wire logic [7:0]    ioWrData,
  output logic [7:0]         ioRdData,
  output logic               ioRdValid,
  // configuration from extension registers (outside this block)
  input  wire logic          switchReadbackEn,
  input  wire logic          cfgClkBit,
  // pins
  input  wire logic [15:0]   videoMemoryDataLines,
  input  wire logic          lightPenSwitchPin,
  input  wire logic          lightPenTrigPin,
  // display status from the CRT timing logic, same clock
  input  wire logic          displayStatus,
  input  wire logic [2:0]    videoStatusMux,
  input  wire logic          vertRetrace,
  input  wire logic [15:0]   lightPenAddr,
  // per character attribute from the fetch path
  input  wire logic [7:0]    attrByte,
  // outputs
  output logic               videoDriversOff,
  output ega_dot_clk_t       dotClkSel,
  output logic [1:0]         fontMapSel,
  output logic               monitorTypeStrapBit,
  output logic [3:0]         switchField,
  output logic [7:0]         miscOutput,
  output logic [7:0]         clockingMode,
  output logic [7:0]         memoryMode,
  output logic               attrWrite,
  output logic [7:0]         attrWrData,
  output logic [7:0]         featureControl,
  output logic [4:0]         gfxIndex,
  output logic               gfxWrite,
  output logic [7:0]         gfxWrData,
  output logic [15:0]        startAddr,
  output logic [15:0]        cursorAddr,
  output logic               crtWrite,
  output logic [4:0]         crtIndex,
  output logic [7:0]         crtWrData
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] penSwMeta_q, penSwMeta_d;
  logic [1:0] penTrMeta_q, penTrMeta_d;
  logic [4:0] strapMeta_q, strapMeta_d;
  logic [4:0] strapSync_q, strapSync_d;

  always_comb begin
    penSwMeta_d = {penSwMeta_q[0], lightPenSwitchPin};
    penTrMeta_d = {penTrMeta_q[0], lightPenTrigPin};
    strapMeta_d = {videoMemoryDataLines[`EGA_MD_SW_LSB +: 4],
                   videoMemoryDataLines[`EGA_MD_MONITOR_BIT]};
    strapSync_d = strapMeta_q;
  end

  always_ff @(posedge clk) begin
    penSwMeta_q <= penSwMeta_d;
    penTrMeta_q <= penTrMeta_d;
    strapMeta_q <= strapMeta_d;
    strapSync_q <= strapSync_d;
  end

  // ----------------------------------------------------------------
  // strap capture: four cycles after reset release, straps are settled
  // ----------------------------------------------------------------
  ega_strap_st_t strapSt_q, strapSt_d;
  logic [1:0]    strapWait_q, strapWait_d;
  logic          monitor_q, monitor_d;
  logic [3:0]    switches_q, switches_d;

  always_comb begin
    strapSt_d   = strapSt_q;
    strapWait_d = strapWait_q;
    monitor_d   = monitor_q;
    switches_d  = switches_q;
    unique case (strapSt_q)
      EGA_STRAP_WAIT: begin
        strapWait_d = strapWait_q + 2'h1;
        if (strapWait_q == 2'h3) begin
          monitor_d  = ~strapSync_q[0];
          switches_d = strapSync_q[4:1];
          strapSt_d  = EGA_STRAP_DONE;
        end
      end
      EGA_STRAP_DONE: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      strapSt_q   <= EGA_STRAP_WAIT;
      strapWait_q <= 2'h0;
      monitor_q   <= 1'b0;
      switches_q  <= 4'h0;
    end else begin
      strapSt_q   <= strapSt_d;
      strapWait_q <= strapWait_d;
      monitor_q   <= monitor_d;
      switches_q  <= switches_d;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [7:0] misc_q, misc_d;
  logic       colorMode;
  logic [9:0] varBase;
  logic       hitMisc, hitAttr, hitSeqIdx, hitSeqDat, hitGfxIdx, hitGfxDat;
  logic       hitCrtIdx, hitCrtDat, hitStat1;

  always_comb begin
    colorMode = misc_q[`EGA_MISC_COLOR_BIT];
    varBase   = colorMode ? `EGA_PORT_COLOR_BASE : `EGA_PORT_MONO_BASE;
    hitMisc   = ioAddr == `EGA_PORT_MISC;
    hitAttr   = ioAddr == `EGA_PORT_ATTR0 || ioAddr == `EGA_PORT_ATTR1;
    hitSeqIdx = ioAddr == `EGA_PORT_SEQ_IDX;
    hitSeqDat = ioAddr == `EGA_PORT_SEQ_DAT;
    hitGfxIdx = ioAddr == `EGA_PORT_GFX_IDX;
    hitGfxDat = ioAddr == `EGA_PORT_GFX_DAT;
    hitCrtIdx = ioAddr == (varBase | {6'h00, `EGA_OFS_CRT_IDX});
    hitCrtDat = ioAddr == (varBase | {6'h00, `EGA_OFS_CRT_DAT});
    hitStat1  = ioAddr == (varBase | {6'h00, `EGA_OFS_STATUS1});
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  logic [2:0]  seqIdx_q, seqIdx_d;
  logic [7:0]  clkMode_q, clkMode_d;
  logic [7:0]  charMap_q, charMap_d;
  logic [7:0]  memMode_q, memMode_d;
  logic [7:0]  feat_q, feat_d;
  logic [4:0]  gfxIdx_q, gfxIdx_d;
  logic [4:0]  crtIdx_q, crtIdx_d;
  logic [15:0] start_q, start_d;
  logic [15:0] cursor_q, cursor_d;
  logic        attrWr_q, attrWr_d;
  logic        gfxWr_q, gfxWr_d;
  logic        crtWr_q, crtWr_d;
  logic [7:0]  wrData_q, wrData_d;

  always_comb begin
    misc_d    = misc_q;
    seqIdx_d  = seqIdx_q;
    clkMode_d = clkMode_q;
    charMap_d = charMap_q;
    memMode_d = memMode_q;
    feat_d    = feat_q;
    gfxIdx_d  = gfxIdx_q;
    crtIdx_d  = crtIdx_q;
    start_d   = start_q;
    cursor_d  = cursor_q;
    attrWr_d  = 1'b0;
    gfxWr_d   = 1'b0;
    crtWr_d   = 1'b0;
    wrData_d  = wrData_q;
    if (ioWr) begin
      wrData_d = ioWrData;
      if (hitMisc) misc_d = ioWrData;
      if (hitAttr) attrWr_d = 1'b1;
      if (hitSeqIdx) seqIdx_d = ioWrData[2:0];
      if (hitGfxIdx) gfxIdx_d = ioWrData[4:0];
      if (hitGfxDat) gfxWr_d = 1'b1;
      if (hitCrtIdx) crtIdx_d = ioWrData[4:0];
      if (hitStat1) feat_d = ioWrData;
      if (hitSeqDat) begin
        unique case (seqIdx_q)
          `EGA_SEQ_CLOCKING: clkMode_d = ioWrData;
          `EGA_SEQ_CHARMAP:  charMap_d = ioWrData;
          `EGA_SEQ_MEMMODE:  memMode_d = ioWrData;
          default: begin
          end
        endcase
      end
      // light pen indices are read-only here; the write goes to the timing regs
      if (hitCrtDat) begin
        crtWr_d = 1'b1;
        unique case (crtIdx_q)
          `EGA_CRT_START_HI: start_d[15:8] = ioWrData;
          `EGA_CRT_START_LO: start_d[7:0]  = ioWrData;
          `EGA_CRT_CURS_HI:  cursor_d[15:8] = ioWrData;
          `EGA_CRT_CURS_LO:  cursor_d[7:0]  = ioWrData;
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      misc_q    <= `EGA_RESET_BYTE;
      seqIdx_q  <= 3'h0;
      clkMode_q <= `EGA_RESET_BYTE;
      charMap_q <= `EGA_RESET_BYTE;
      memMode_q <= `EGA_RESET_BYTE;
      feat_q    <= `EGA_RESET_BYTE;
      gfxIdx_q  <= 5'h00;
      crtIdx_q  <= 5'h00;
      start_q   <= 16'h0000;
      cursor_q  <= 16'h0000;
      attrWr_q  <= 1'b0;
      gfxWr_q   <= 1'b0;
      crtWr_q   <= 1'b0;
      wrData_q  <= `EGA_RESET_BYTE;
    end else begin
      misc_q    <= misc_d;
      seqIdx_q  <= seqIdx_d;
      clkMode_q <= clkMode_d;
      charMap_q <= charMap_d;
      memMode_q <= memMode_d;
      feat_q    <= feat_d;
      gfxIdx_q  <= gfxIdx_d;
      crtIdx_q  <= crtIdx_d;
      start_q   <= start_d;
      cursor_q  <= cursor_d;
      attrWr_q  <= attrWr_d;
      gfxWr_q   <= gfxWr_d;
      crtWr_q   <= crtWr_d;
      wrData_q  <= wrData_d;
    end
  end

  // ----------------------------------------------------------------
  // read path and status
  // ----------------------------------------------------------------
  logic [7:0] stat0, stat1, rdData_d, rdData_q;
  logic       rdValid_d, rdValid_q;

  always_comb begin
    stat0 = `EGA_STAT0_ONES;
    stat0[7] = vertRetrace;
    stat0[`EGA_STAT0_SW_BIT] = switchReadbackEn & |switches_q;
    stat1 = `EGA_STAT1_ONES;
    stat1[5:3] = videoStatusMux;
    stat1[`EGA_STAT1_PEN_SW]   = penSwMeta_q[1];
    stat1[`EGA_STAT1_PEN_TRIG] = penTrMeta_q[1];
    stat1[0] = displayStatus;
    rdData_d  = 8'h00;
    rdValid_d = ioRd;
    if (ioRd) begin
      if (hitMisc) rdData_d = stat0;
      else if (hitStat1) rdData_d = stat1;
      else if (hitCrtDat) begin
        unique case (crtIdx_q)
          `EGA_CRT_START_HI: rdData_d = start_q[15:8];
          `EGA_CRT_START_LO: rdData_d = start_q[7:0];
          `EGA_CRT_CURS_HI:  rdData_d = cursor_q[15:8];
          `EGA_CRT_CURS_LO:  rdData_d = cursor_q[7:0];
          `EGA_CRT_PEN_HI:   rdData_d = lightPenAddr[15:8];
          `EGA_CRT_PEN_LO:   rdData_d = lightPenAddr[7:0];
          default:           rdData_d = `EGA_ERR_BYTE;
        endcase
      end
      else rdData_d = `EGA_ERR_BYTE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_q  <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      rdData_q  <= rdData_d;
      rdValid_q <= rdValid_d;
    end
  end

  // ----------------------------------------------------------------
  // display-side controls
  // ----------------------------------------------------------------
  ega_dot_clk_t dotClk, dotClk_q;
  logic [1:0]   fontMap_d, fontMap_q;
  logic         drvOff_q;

  ega_dot_clock_select uClkSel (
    .clockSel  (misc_q[`EGA_MISC_CLK_LSB +: 2]),
    .cfgClkBit (cfgClkBit),
    .dotClk    (dotClk)
  );

  always_comb begin
    // map A on bit 3 set, map B otherwise
    fontMap_d = attrByte[`EGA_ATTR_MAP_BIT] ? charMap_q[3:2]
                                            : charMap_q[1:0];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dotClk_q  <= EGA_CLK_BASE;
      fontMap_q <= 2'h0;
      drvOff_q  <= 1'b0;
    end else begin
      dotClk_q  <= dotClk;
      fontMap_q <= fontMap_d;
      drvOff_q  <= misc_q[`EGA_MISC_DRVOFF_BIT];
    end
  end

  assign ioRdData            = rdData_q;
  assign ioRdValid           = rdValid_q;
  assign videoDriversOff     = drvOff_q;
  assign dotClkSel           = dotClk_q;
  assign fontMapSel          = fontMap_q;
  assign monitorTypeStrapBit = monitor_q;
  assign switchField         = switches_q;
  assign miscOutput          = misc_q;
  assign clockingMode        = clkMode_q;
  assign memoryMode          = memMode_q;
  assign attrWrite           = attrWr_q;
  assign attrWrData          = wrData_q;
  assign featureControl      = feat_q;
  assign gfxIndex            = gfxIdx_q;
  assign gfxWrite            = gfxWr_q;
  assign gfxWrData           = wrData_q;
  assign startAddr           = start_q;
  assign cursorAddr          = cursor_q;
  assign crtWrite            = crtWr_q;
  assign crtIndex            = crtIdx_q;
  assign crtWrData           = wrData_q;

endmodule : ega_compat_register_set
`default_nettype wire

/* verification/ega_host_model.sv */
// host processor model on the I/O bus
`timescale 1ns/1ps
`default_nettype none
module ega_host_model (
  input  wire logic       clk,
  output logic [9:0]      ioAddr,
  output logic            ioWr,
  output logic            ioRd,
  output logic [7:0]      ioWrData,
  input  wire logic [7:0] ioRdData,
  input  wire logic       ioRdValid
);
  initial begin
    ioAddr = 10'h000;
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioWrData = 8'h00;
  end
  // ---------------------------------------------
  // bus cycles, one strobe cycle, driven at fall
  // ---------------------------------------------
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    ioAddr = a;
    ioWrData = d;
    ioWr = 1'b1;
    @(negedge clk);
    ioWr = 1'b0;
    // released data never shows the last byte
    ioWrData = ~d;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [7:0] d, output bit ok);
    int n;
    @(negedge clk);
    ioAddr = a;
    ioRd = 1'b1;
    @(negedge clk);
    ioRd = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    // valid stands one cycle only, from the edge that took the strobe
    for (n = 0; n < 4 && !ok; n++) begin
      if (ioRdValid === 1'b1) begin
        d = ioRdData;
        ok = 1'b1;
      end else begin
        @(negedge clk);
      end
    end
  endtask : rd
endmodule : ega_host_model
`default_nettype wire

/* verification/ega_compat_register_set_asserts.sv */
// port assertions for the compatibility register set
`timescale 1ns/1ps
`default_nettype none
module ega_compat_register_set_asserts
  import ega_pkg::*;
(
  input wire logic         clk,
  input wire logic         srst,
  input wire logic [9:0]   ioAddr,
  input wire logic         ioWr,
  input wire logic         ioRd,
  input wire logic [7:0]   ioWrData,
  input wire logic [7:0]   ioRdData,
  input wire logic         ioRdValid,
  input wire logic         switchReadbackEn,
  input wire logic         cfgClkBit,
  input wire logic         displayStatus,
  input wire logic [2:0]   videoStatusMux,
  input wire logic         vertRetrace,
  input wire logic [7:0]   attrByte,
  input wire logic         videoDriversOff,
  input wire ega_dot_clk_t dotClkSel,
  input wire logic [1:0]   fontMapSel,
  input wire logic [3:0]   switchField,
  input wire logic [7:0]   miscOutput,
  input wire logic         attrWrite,
  input wire logic [7:0]   attrWrData
);
  // ---------------------------------------------
  // shadow of the character map register
  // ---------------------------------------------
  logic [2:0] seqIdx_q;
  logic [7:0] charMap_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      seqIdx_q <= 3'h0;
      charMap_q <= 8'h00;
    end else if (ioWr && ioAddr == 10'h3c4) begin
      seqIdx_q <= ioWrData[2:0];
    end else if (ioWr && ioAddr == 10'h3c5 && seqIdx_q == 3'h3) begin
      charMap_q <= ioWrData;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_rd_taken(logic [9:0] a);
    ioRd && ioAddr == a;
  endsequence
  a_misc_write_load: assert property (
    ioWr && ioAddr == 10'h3c2 |=> miscOutput == $past(ioWrData)) else $error("misc not loaded");
  a_drivers_off_follow: assert property (
    videoDriversOff == $past(miscOutput[4])) else $error("driver disable wrong");
  a_clock_base_pick: assert property (
    miscOutput[3:2] == 2'b00 |=> dotClkSel == EGA_CLK_BASE) else $error("base clock wrong");
  a_clock_second_pick: assert property (
    miscOutput[3:2] == 2'b01 && !cfgClkBit |=> dotClkSel == EGA_CLK_SECONDARY)
    else $error("secondary clock wrong");
  a_clock_feature_pick: assert property (
    miscOutput[3] && !cfgClkBit |=> dotClkSel == EGA_CLK_FEATURE) else $error("feature clock wrong");
  a_status_zero_read: assert property (
    s_rd_taken(10'h3c2) |=> ioRdValid && ioRdData == {$past(vertRetrace), 2'b00,
    $past(switchReadbackEn) & (|$past(switchField)), 4'hf}) else $error("status zero wrong");
  a_status_one_read: assert property (
    s_rd_taken(miscOutput[0] ? 10'h3da : 10'h3ba) |=> ioRdData[7:6] == 2'b01
    && ioRdData[5:3] == $past(videoStatusMux) && ioRdData[0] == $past(displayStatus))
    else $error("status one wrong");
  a_unmapped_read_ff: assert property (
    s_rd_taken(10'h3c9) |=> ioRdData == 8'hff) else $error("unmapped read wrong");
  a_read_valid_pulse: assert property (
    ioRdValid == ($past(ioRd) && !$past(srst))) else $error("read valid wrong");
  a_font_map_pick: assert property (
    fontMapSel == ($past(attrByte[3]) ? $past(charMap_q[3:2]) : $past(charMap_q[1:0])))
    else $error("font map wrong");
  a_attr_port_alias: assert property (
    ioWr && (ioAddr == 10'h3c0 || ioAddr == 10'h3c1) |=> attrWrite
    && attrWrData == $past(ioWrData)) else $error("attribute write wrong");
endmodule : ega_compat_register_set_asserts
bind ega_compat_register_set ega_compat_register_set_asserts u_chk (.clk, .srst, .ioAddr,
  .ioWr, .ioRd, .ioWrData, .ioRdData, .ioRdValid, .switchReadbackEn, .cfgClkBit, .displayStatus,
  .videoStatusMux, .vertRetrace, .attrByte, .videoDriversOff, .dotClkSel, .fontMapSel,
  .switchField, .miscOutput, .attrWrite, .attrWrData);
`default_nettype wire

/* verification/ega_compat_register_set_tb_top.sv */
// self-checking bench for the compatibility register set
`timescale 1ns/1ps
`default_nettype none
module ega_compat_register_set_tb_top;
  import ega_pkg::*;
  logic         clk, srst, ioWr, ioRd, ioRdValid, switchReadbackEn, cfgClkBit, vertRetrace;
  logic         lightPenSwitchPin, lightPenTrigPin, displayStatus, attrWrite;
  logic         videoDriversOff, monitorTypeStrapBit;
  logic [9:0]   ioAddr;
  logic [7:0]   ioWrData, ioRdData, attrByte, miscOutput, attrWrData, rdv, ex;
  logic [7:0]   clockingMode, memoryMode, gfxWrData, crtWrData;
  logic [4:0]   gfxIndex, crtIndex;
  logic         gfxWrite, crtWrite;
  logic [15:0]  videoMemoryDataLines, lightPenAddr, startAddr, cursorAddr;
  logic [31:0]  rnd;
  logic [3:0]   switchField;
  logic [2:0]   videoStatusMux;
  logic [1:0]   fontMapSel;
  logic [7:0]   crt [4];
  ega_dot_clk_t dotClkSel;
  int           errorCnt, checks, mMisc;
  bit           ok;
  ega_compat_register_set dut (.clk, .srst, .ioAddr, .ioWr, .ioRd, .ioWrData, .ioRdData,
    .ioRdValid, .switchReadbackEn, .cfgClkBit, .videoMemoryDataLines, .lightPenSwitchPin,
    .lightPenTrigPin, .displayStatus, .videoStatusMux, .vertRetrace, .lightPenAddr, .attrByte,
    .videoDriversOff, .dotClkSel, .fontMapSel, .monitorTypeStrapBit, .switchField, .miscOutput,
    .clockingMode, .memoryMode, .attrWrite, .attrWrData, .featureControl(), .gfxIndex,
    .gfxWrite, .gfxWrData, .startAddr, .cursorAddr, .crtWrite, .crtIndex, .crtWrData);
  ega_host_model hst (.clk, .ioAddr, .ioWr, .ioRd, .ioWrData, .ioRdData, .ioRdValid);
  always #12.5 clk = ~clk;
  // ---------------------------------------------
  // model and comparison helpers
  // ---------------------------------------------
  function automatic logic [9:0] base();
    return mMisc[0] ? 10'h3d0 : 10'h3b0;
  endfunction : base
  function automatic ega_dot_clk_t expClk(logic [1:0] sel, logic cfg);
    if (sel == 2'b00) return EGA_CLK_BASE;
    if (cfg) return EGA_CLK_NONE;
    return (sel == 2'b01) ? EGA_CLK_SECONDARY : EGA_CLK_FEATURE;
  endfunction : expClk
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic rdchk(input string what, input logic [9:0] a, input logic [7:0] exp);
    hst.rd(a, rdv, ok);
    if (!ok) begin
      errorCnt++;
      report_and_stop();
    end else begin
      chk(what, rdv, exp);
    end
  endtask : rdchk
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h113d));
    clk = 1'b0;
    srst = 1'b1;
    errorCnt = 0;
    checks = 0;
    mMisc = 0;
    rnd = $urandom();
    // straps held from reset until well after capture
    videoMemoryDataLines = rnd[15:0] | 16'h2000;
    {switchReadbackEn, vertRetrace, displayStatus, lightPenSwitchPin, lightPenTrigPin,
      videoStatusMux, attrByte} = rnd[31:16];
    cfgClkBit = 1'b0;
    lightPenAddr = 16'h0000;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    repeat (8) @(negedge clk);
    chk("switches", switchField, videoMemoryDataLines[15:12]);
    chk("monitor", monitorTypeStrapBit, !videoMemoryDataLines[11]);
    for (int i = 0; i < 16; i++) begin
      rnd = $urandom();
      cfgClkBit = i[3];
      mMisc = (rnd[7:0] & 8'he3) | (i[2:0] << 2);
      hst.wr(10'h3c2, mMisc[7:0]);
      repeat (2) @(negedge clk);
      chk("misc", miscOutput, mMisc[7:0]);
      chk("drivers off", videoDriversOff, mMisc[4]);
      chk("dot clock", dotClkSel, expClk(mMisc[3:2], cfgClkBit));
      // switch readback enable stands for the host's compat setting
      {switchReadbackEn, vertRetrace, displayStatus, lightPenSwitchPin, lightPenTrigPin,
        videoStatusMux, attrByte} = rnd[31:16];
      lightPenAddr = rnd[23:8];
      repeat (3) @(negedge clk);
      ex = {vertRetrace, 2'b00, switchReadbackEn & (|videoMemoryDataLines[15:12]), 4'hf};
      rdchk("status zero", 10'h3c2, ex);
      ex = {2'b01, videoStatusMux, lightPenSwitchPin, lightPenTrigPin, displayStatus};
      rdchk("status one", base() + 10'h00a, ex);
      rdchk("other base", (base() ^ 10'h060) + 10'h00a, 8'hff);
      hst.wr(10'h3c4, 8'h03);
      hst.wr(10'h3c5, {4'h0, rnd[11:8]});
      repeat (2) @(negedge clk);
      chk("font map", fontMapSel, attrByte[3] ? rnd[11:10] : rnd[9:8]);
      hst.wr(i[0] ? 10'h3c1 : 10'h3c0, rnd[7:0]);
      chk("attribute data", attrWrData, rnd[7:0]);
      chk("attribute strobe", attrWrite, 1'b1);
      hst.wr(10'h3c4, 8'h01);
      hst.wr(10'h3c5, {4'h0, rnd[15:14], 1'b0, rnd[12]});
      chk("clocking mode", clockingMode, {4'h0, rnd[15:14], 1'b0, rnd[12]});
      hst.wr(10'h3c4, 8'h04);
      hst.wr(10'h3c5, {4'h0, rnd[19:16]});
      chk("memory mode", memoryMode, {4'h0, rnd[19:16]});
      hst.wr(10'h3ce, {3'h0, rnd[28:24]});
      hst.wr(10'h3cf, rnd[31:24]);
      chk("graphics strobe", gfxWrite, 1'b1);
      chk("graphics data", gfxWrData, rnd[31:24]);
      chk("graphics index", gfxIndex, rnd[28:24]);
    end
    for (int k = 0; k < 6; k++) begin
      rnd = $urandom();
      hst.wr(base() + 10'h004, 8'h0c + k[7:0]);
      chk("crtc index", crtIndex, 5'h0c + k[4:0]);
      hst.wr(base() + 10'h005, rnd[7:0]);
      chk("crtc strobe", crtWrite, 1'b1);
      chk("crtc data", crtWrData, rnd[7:0]);
      if (k < 4) crt[k] = rnd[7:0];
      ex = (k < 4) ? rnd[7:0] : ((k == 4) ? lightPenAddr[15:8] : lightPenAddr[7:0]);
      rdchk("crtc", base() + 10'h005, ex);
    end
    chk("start", startAddr, {crt[0], crt[1]});
    chk("cursor", cursorAddr, {crt[2], crt[3]});
    rdchk("unmapped", 10'h3c9, 8'hff);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    mMisc = 0;
    @(negedge clk);
    chk("misc after reset", miscOutput, 8'h00);
    chk("clock after reset", dotClkSel, EGA_CLK_BASE);
    report_and_stop();
  end
endmodule : ega_compat_register_set_tb_top
`default_nettype wire
